// file: csfa_core.sv
`timescale 1ns/10ps
// ============================================================
// Work register and status word of the core.
module csfa_core
   import csfa_pkg::*;
(
   // Clock and reset sources.
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ext_reset_pin_low,
   input  wire logic        break_reset,
   input  wire logic        wdt_reset,
   input  wire logic        trap_reset,
   // Instruction command.
   input  wire logic        cmd_valid,
   input  wire csfa_op_t    cmd_op,
   input  wire csfa_width_t cmd_width,
   input  wire logic [15:0] cmd_operand,
   input  wire logic [3:0]  cmd_bit_sel,
   input  wire logic        cmd_bit_in_sw,
   input  wire logic        cmd_bit_val,
   // Direct status word writes.
   input  wire logic [1:0]  sw_wr_be,
   input  wire logic [15:0] sw_wr_data,
   // Interrupt entry and return.
   input  wire logic        int_enter,
   input  wire logic        int_maskable,
   input  wire logic        int_return,
   input  wire logic [15:0] int_restore_data,
   input  wire logic        maskable_req,
   // Data memory word access.
   input  wire logic        mem_req,
   input  wire logic        mem_word,
   input  wire logic [15:0] mem_addr,
   // Register views.
   output logic      [15:0] awr_ff,
   output logic      [15:0] sw_ff,
   output logic             width_view_ff,
   output logic      [4:0]  bit_offset_ff,
   output logic      [2:0]  bit_num_ff,
   // Interrupt save and gating.
   output logic      [15:0] sw_save_data_ff,
   output logic             sw_save_valid_ff,
   output logic             maskable_take_ff,
   // Address helpers.
   output logic      [15:0] common_top_ff,
   output logic      [15:0] ptr_set_base_ff,
   output logic             mem_valid_ff,
   output logic      [15:0] mem_lo_addr_ff,
   output logic      [15:0] mem_hi_addr_ff
);
   // ==========================================================
   // Helper functions.
   function automatic logic [15:0] width_mask(input csfa_width_t w);
      case (w)
         CSFA_W_WORD: width_mask = CSFA_MASK_WORD;
         CSFA_W_NIB:  width_mask = CSFA_MASK_NIB;
         default:     width_mask = CSFA_MASK_BYTE;
      endcase
   endfunction

   function automatic logic [15:0] common_top(input logic [1:0] sel);
      case (sel)
         2'b00:   common_top = CSFA_CA_TOP_0;
         2'b01:   common_top = CSFA_CA_TOP_1;
         2'b10:   common_top = CSFA_CA_TOP_2;
         default: common_top = CSFA_CA_TOP_3;
      endcase
   endfunction

   // ==========================================================
   // Decode.
   logic        any_rst;
   csfa_width_t eff_width;
   logic [15:0] eff_mask;
   logic        is_word;
   logic        is_bitop;
   logic        take_cmd;
   logic        take_wr;
   logic        take_enter;
   logic        old_bit;
   logic [1:0]  logic_sel;
   logic [15:0] alu_res;
   logic        alu_carry;
   logic        alu_half;
   logic        alu_range;
   logic        alu_zero;
   logic        alu_neg;
   logic [15:0] nxt_awr;
   logic [15:0] nxt_sw;
   logic        nxt_width_view;

   // Every reset cause acts as the same synchronous clear.
   assign any_rst = rst | ~ext_reset_pin_low | break_reset | wdt_reset | trap_reset;

   // Descriptor width resolves through the delayed view of the width flag.
   assign eff_width = (cmd_width == CSFA_W_DESC) ?
                      (width_view_ff ? CSFA_W_WORD : CSFA_W_BYTE) : cmd_width;
   assign eff_mask  = width_mask(eff_width);
   assign is_word   = (eff_width == CSFA_W_WORD);
   assign is_bitop  = (cmd_op == CSFA_OP_BIT_SET) || (cmd_op == CSFA_OP_BIT_CLR) ||
                      (cmd_op == CSFA_OP_BIT_TST);
   assign logic_sel = (cmd_op == CSFA_OP_AND) ? 2'h1 :
                      (cmd_op == CSFA_OP_OR)  ? 2'h2 :
                      (cmd_op == CSFA_OP_XOR) ? 2'h3 : 2'h0;
   assign old_bit   = cmd_bit_in_sw ? sw_ff[cmd_bit_sel] : cmd_bit_val;

   // Priority: return, entry, direct write, then instruction.
   assign take_enter = int_enter & ~int_return;
   assign take_wr    = (sw_wr_be != 2'b00) & ~int_return & ~int_enter;
   assign take_cmd   = cmd_valid & ~int_return & ~int_enter & (sw_wr_be == 2'b00);

   csfa_alu u_alu (
      .a         (awr_ff),
      .b         (cmd_operand),
      .is_word   (is_word),
      .is_sub    ((cmd_op == CSFA_OP_SUB) || (cmd_op == CSFA_OP_CMP)),
      .logic_sel (logic_sel),
      .result    (alu_res),
      .carry     (alu_carry),
      .half      (alu_half),
      .range_err (alu_range),
      .zero      (alu_zero),
      .neg       (alu_neg)
   );

   // ==========================================================
   // Next state of the work register and status word.
   // Flags not named by an operation simply keep their value.
   always_comb begin
      nxt_awr        = awr_ff;
      nxt_sw         = sw_ff;
      nxt_width_view = width_view_ff;
      if (int_return) begin
         nxt_sw         = int_restore_data;
         nxt_width_view = int_restore_data[CSFA_B_WIDTH];
      end else if (take_enter) begin
         if (int_maskable) begin
            nxt_sw[CSFA_B_MIE] = 1'b0;
         end
      end else if (take_wr) begin
         // Direct writes change the width flag view one instruction late.
         nxt_width_view = sw_ff[CSFA_B_WIDTH];
         if (sw_wr_be[1]) begin
            nxt_sw[15:8] = sw_wr_data[15:8];
         end
         if (sw_wr_be[0]) begin
            nxt_sw[7:0] = sw_wr_data[7:0];
         end
      end else if (take_cmd) begin
         nxt_width_view = sw_ff[CSFA_B_WIDTH];
         case (cmd_op)
            CSFA_OP_ADD, CSFA_OP_SUB, CSFA_OP_CMP: begin
               nxt_sw[CSFA_B_CARRY] = alu_carry;
               nxt_sw[CSFA_B_ZERO]  = alu_zero;
               nxt_sw[CSFA_B_HALF]  = alu_half;
               nxt_sw[CSFA_B_NEG]   = alu_neg;
               nxt_sw[CSFA_B_RANGE] = alu_range;
               if (cmd_op != CSFA_OP_CMP) begin
                  nxt_awr = (awr_ff & ~eff_mask) | (alu_res & eff_mask);
               end
            end
            CSFA_OP_AND, CSFA_OP_OR, CSFA_OP_XOR: begin
               nxt_sw[CSFA_B_ZERO] = alu_zero;
               nxt_sw[CSFA_B_NEG]  = alu_neg;
               nxt_awr = (awr_ff & ~eff_mask) | (alu_res & eff_mask);
            end
            CSFA_OP_LOAD: begin
               nxt_awr = (awr_ff & ~eff_mask) | (cmd_operand & eff_mask);
               nxt_sw[CSFA_B_ZERO] = ((cmd_operand & eff_mask) == 16'h0000);
               if (eff_width != CSFA_W_NIB) begin
                  nxt_sw[CSFA_B_WIDTH] = is_word;
                  nxt_width_view       = is_word;
               end
            end
            CSFA_OP_LOAD_SW: begin
               // Zero flag is left alone since its value is undefined here.
               nxt_awr = (awr_ff & ~eff_mask) | (sw_ff & eff_mask);
            end
            CSFA_OP_SET_WID: begin
               nxt_sw[CSFA_B_WIDTH] = 1'b1;
               nxt_width_view       = 1'b1;
            end
            CSFA_OP_CLR_WID: begin
               nxt_sw[CSFA_B_WIDTH] = 1'b0;
               nxt_width_view       = 1'b0;
            end
            CSFA_OP_BIT_SET, CSFA_OP_BIT_CLR, CSFA_OP_BIT_TST: begin
               if (cmd_bit_in_sw && (cmd_op != CSFA_OP_BIT_TST)) begin
                  nxt_sw[cmd_bit_sel] = (cmd_op == CSFA_OP_BIT_SET);
               end
               // Zero reflects the old target bit, so a zero target sees its prior value.
               nxt_sw[CSFA_B_ZERO] = ~old_bit;
            end
            CSFA_OP_CY_LOAD: begin
               nxt_sw[CSFA_B_CARRY] = cmd_bit_val;
            end
            default: begin
               nxt_sw = sw_ff;
            end
         endcase
      end
   end

   // ==========================================================
   // Registers.
   always_ff @(posedge clk) begin
      if (any_rst) begin
         awr_ff        <= CSFA_AWR_RESET;
         sw_ff         <= CSFA_SW_RESET;
         width_view_ff <= 1'b0;
         bit_offset_ff <= 5'h00;
         bit_num_ff    <= 3'h0;
      end else begin
         awr_ff        <= nxt_awr;
         sw_ff         <= nxt_sw;
         width_view_ff <= nxt_width_view;
         bit_offset_ff <= nxt_awr[CSFA_OFS_HI:CSFA_OFS_LO];
         bit_num_ff    <= nxt_awr[CSFA_NUM_HI:0];
      end
   end

   // Save the old word on entry; the enable is cleared only afterwards.
   always_ff @(posedge clk) begin
      if (any_rst) begin
         sw_save_data_ff  <= CSFA_SW_RESET;
         sw_save_valid_ff <= 1'b0;
         maskable_take_ff <= 1'b0;
      end else begin
         if (take_enter) begin
            sw_save_data_ff <= sw_ff;
         end
         sw_save_valid_ff <= take_enter;
         maskable_take_ff <= maskable_req & sw_ff[CSFA_B_MIE];
      end
   end

   // Region decode follows the status word as it will stand next cycle.
   always_ff @(posedge clk) begin
      if (any_rst) begin
         common_top_ff   <= CSFA_CA_TOP_0;
         ptr_set_base_ff <= CSFA_PS_BASE;
      end else begin
         common_top_ff   <= common_top(nxt_sw[CSFA_B_CA_HI:CSFA_B_CA_LO]);
         ptr_set_base_ff <= CSFA_PS_BASE +
                            ({13'h0000, nxt_sw[CSFA_B_PS_HI:CSFA_B_PS_LO]}
                             << CSFA_PS_STEP_LSH);
      end
   end

   // Word accesses never straddle a pair; the address bit 0 is dropped.
   always_ff @(posedge clk) begin
      if (any_rst) begin
         mem_valid_ff   <= 1'b0;
         mem_lo_addr_ff <= 16'h0000;
         mem_hi_addr_ff <= 16'h0000;
      end else begin
         mem_valid_ff <= mem_req;
         if (mem_req) begin
            mem_lo_addr_ff <= mem_word ? {mem_addr[15:1], 1'b0} : mem_addr;
            mem_hi_addr_ff <= mem_word ? {mem_addr[15:1], 1'b1} : mem_addr;
         end
      end
   end

   // ==========================================================
   // Checks.
   sequence s_entry;
      take_enter && int_maskable;
   endsequence

   sequence s_saved_cleared;
      (sw_save_data_ff == $past(sw_ff)) && !sw_ff[CSFA_B_MIE] && sw_save_valid_ff;
   endsequence

   a_reset_clears:
      assert property (@(posedge clk) any_rst |=> (awr_ff == 16'h0000) && (sw_ff == 16'h0000))
      else $error("reset did not clear work register and status word");

   a_bitsel_split:
      assert property (@(posedge clk) disable iff (any_rst)
         ##1 (bit_offset_ff == awr_ff[7:3]) && (bit_num_ff == awr_ff[2:0]))
      else $error("bit select split does not match work register");

   a_carry_word:
      assert property (@(posedge clk) disable iff (any_rst)
         take_cmd && (cmd_op == CSFA_OP_ADD) && is_word |=>
         sw_ff[15] == ((({1'b0, $past(awr_ff)} + {1'b0, $past(cmd_operand)}) >> 16) != 17'h0))
      else $error("word add carry wrong");

   a_zero_bitop:
      assert property (@(posedge clk) disable iff (any_rst)
         take_cmd && is_bitop && cmd_bit_in_sw && (cmd_bit_sel == 4'hE) |=>
         sw_ff[14] == !$past(sw_ff[14]))
      else $error("bit op on zero flag ignored prior value");

   a_width_fast:
      assert property (@(posedge clk) disable iff (any_rst)
         take_cmd && (cmd_op == CSFA_OP_SET_WID) |=> width_view_ff && sw_ff[12])
      else $error("width set not seen by next instruction");

   a_width_slow:
      assert property (@(posedge clk) disable iff (any_rst)
         take_wr && sw_wr_be[1] && (sw_wr_data[12] != sw_ff[12]) |=>
         (width_view_ff != sw_ff[12]))
      else $error("direct width write seen too early");

   a_int_save:
      assert property (@(posedge clk) disable iff (any_rst) s_entry |=> s_saved_cleared)
      else $error("interrupt entry save or enable clear wrong");

   a_int_restore:
      assert property (@(posedge clk) disable iff (any_rst)
         int_return |=> sw_ff == $past(int_restore_data))
      else $error("interrupt return did not restore status word");

   a_common_top:
      assert property (@(posedge clk) disable iff (any_rst)
         ##1 (sw_ff[5:4] == 2'b00) |-> (common_top_ff == 16'h03FF))
      else $error("common area top wrong");

   a_word_align:
      assert property (@(posedge clk) disable iff (any_rst)
         mem_req && mem_word |=> !mem_lo_addr_ff[0] && (mem_hi_addr_ff == mem_lo_addr_ff + 16'h1))
      else $error("word access not aligned");
endmodule // csfa_core

// file: csfa_pkg.sv
// Overview of operation
// - Work register: word 16, byte 8, nibble 4.
// - Bit target: bits 7..3 offset, 2..0 bit.
// - Any reset cause clears the work register.
// - Any reset cause clears the status word.
// - Status word writable whole or per byte.
// - Zero flag undefined after status copy.
// - Bit op on zero uses prior zero.
// - Arithmetic on status word gives undefined result.
// - Interrupt saves status word; return restores it.
// - Carry from bit 7 or bit 15.
// - Carry settable, clearable, bit-transfer target.
// - Zero from result, load, or bit.
// - Half carry from bit 3.
// - Width flag picks word or byte operation.
// - Width flag follows loads and width instructions.
// - Instruction width changes seen next, direct writes later.
// - Negative flag copies result MSB.
// - Range error on signed overflow.
// - Three user flags, no side effects.
// - Common area select picks shared region top.
// - Word access forces even address.
// - Interrupt enable cleared after save on entry.
// - Common area select in bits 5..4.
// - Pointer set select picks eight-byte block.
package csfa_pkg;
   // ==========================================================
   // Reset values.
   localparam logic [15:0] CSFA_AWR_RESET = 16'h0000;
   localparam logic [15:0] CSFA_SW_RESET  = 16'h0000;

   // ==========================================================
   // Status word field positions.
   localparam int CSFA_B_CARRY = 15;
   localparam int CSFA_B_ZERO  = 14;
   localparam int CSFA_B_HALF  = 13;
   localparam int CSFA_B_WIDTH = 12;
   localparam int CSFA_B_NEG   = 11;
   localparam int CSFA_B_USR2  = 10;
   localparam int CSFA_B_RANGE = 9;
   localparam int CSFA_B_MIE   = 8;
   localparam int CSFA_B_USR1  = 6;
   localparam int CSFA_B_CA_HI = 5;
   localparam int CSFA_B_CA_LO = 4;
   localparam int CSFA_B_USR0  = 3;
   localparam int CSFA_B_PS_HI = 2;
   localparam int CSFA_B_PS_LO = 0;

   // ==========================================================
   // Operand width masks and bit-select split.
   localparam logic [15:0] CSFA_MASK_WORD = 16'hFFFF;
   localparam logic [15:0] CSFA_MASK_BYTE = 16'h00FF;
   localparam logic [15:0] CSFA_MASK_NIB  = 16'h000F;
   localparam int          CSFA_OFS_HI    = 7;
   localparam int          CSFA_OFS_LO    = 3;
   localparam int          CSFA_NUM_HI    = 2;

   // ==========================================================
   // Common area tops and pointer set placement.
   localparam logic [15:0] CSFA_CA_TOP_0    = 16'h03FF;
   localparam logic [15:0] CSFA_CA_TOP_1    = 16'h1FFF;
   localparam logic [15:0] CSFA_CA_TOP_2    = 16'h3FFF;
   localparam logic [15:0] CSFA_CA_TOP_3    = 16'h7FFF;
   localparam logic [15:0] CSFA_PS_BASE     = 16'h0200;
   localparam logic [15:0] CSFA_PS_STEP_LSH = 16'h0003;

   // ==========================================================
   // Operations issued by the execution unit.
   typedef enum logic [3:0] {
      CSFA_OP_NOP     = 4'h0,
      CSFA_OP_ADD     = 4'h1,
      CSFA_OP_SUB     = 4'h2,
      CSFA_OP_CMP     = 4'h3,
      CSFA_OP_AND     = 4'h4,
      CSFA_OP_OR      = 4'h5,
      CSFA_OP_XOR     = 4'h6,
      CSFA_OP_LOAD    = 4'h7,
      CSFA_OP_LOAD_SW = 4'h8,
      CSFA_OP_SET_WID = 4'h9,
      CSFA_OP_CLR_WID = 4'hA,
      CSFA_OP_BIT_SET = 4'hB,
      CSFA_OP_BIT_CLR = 4'hC,
      CSFA_OP_BIT_TST = 4'hD,
      CSFA_OP_CY_LOAD = 4'hE
   } csfa_op_t;

   // Operand width, DESC means "use the width flag".
   typedef enum logic [1:0] {
      CSFA_W_BYTE = 2'h0,
      CSFA_W_WORD = 2'h1,
      CSFA_W_NIB  = 2'h2,
      CSFA_W_DESC = 2'h3
   } csfa_width_t;
endpackage

// file: csfa_alu.sv
`timescale 1ns/10ps
// ============================================================
// Adder and logic unit with flag outputs for byte or word.
module csfa_alu
   import csfa_pkg::*;
(
   // Operands and mode.
   input  wire logic [15:0] a,
   input  wire logic [15:0] b,
   input  wire logic        is_word,
   input  wire logic        is_sub,
   input  wire logic [1:0]  logic_sel,
   // Result and flags.
   output logic      [15:0] result,
   output logic             carry,
   output logic             half,
   output logic             range_err,
   output logic             zero,
   output logic             neg
);
   logic [16:0] sum_w;
   logic [8:0]  sum_b;
   logic [4:0]  sum_n;
   logic [15:0] b_eff;
   logic [15:0] arith;
   logic [15:0] logic_res;
   logic        msb_a;
   logic        msb_b;
   logic        msb_r;

   // Separate narrow adders expose the bit 3 and bit 7 carries directly.
   assign sum_w = is_sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
   assign sum_b = is_sub ? ({1'b0, a[7:0]} - {1'b0, b[7:0]}) : ({1'b0, a[7:0]} + {1'b0, b[7:0]});
   assign sum_n = is_sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
   assign b_eff = is_sub ? ~b : b;
   assign arith = is_word ? sum_w[15:0] : {8'h00, sum_b[7:0]};

   // Logic selection; code 0 is the arithmetic path.
   assign logic_res = (logic_sel == 2'h1) ? (a & b) :
                      (logic_sel == 2'h2) ? (a | b) : (a ^ b);
   assign result    = (logic_sel == 2'h0) ? arith :
                      (is_word ? logic_res : {8'h00, logic_res[7:0]});

   // Flag derivation at the active width.
   assign msb_a     = is_word ? a[15] : a[7];
   assign msb_b     = is_word ? b_eff[15] : b_eff[7];
   assign msb_r     = is_word ? result[15] : result[7];
   assign carry     = is_word ? sum_w[16] : sum_b[8];
   assign half      = sum_n[4];
   assign range_err = (msb_a == msb_b) && (msb_r != msb_a);
   assign zero      = (result == 16'h0000);
   assign neg       = msb_r;
endmodule // csfa_alu

// file: csfa_exec_model.sv
`timescale 1ns/10ps
// ==========================================================
// Execution unit stand-in that issues one command per call.
module csfa_exec_model
   import csfa_pkg::*;
(
   // Clock.
   input  wire logic   clk,
   // Command group.
   output logic        cmd_valid,
   output csfa_op_t    cmd_op,
   output csfa_width_t cmd_width,
   output logic [15:0] cmd_operand,
   output logic        cmd_bit_val
);
   // Quiet bus at start.
   initial begin
      cmd_valid   = 1'b0;
      cmd_op      = CSFA_OP_NOP;
      cmd_width   = CSFA_W_BYTE;
      cmd_operand = 16'h0000;
      cmd_bit_val = 1'b0;
   end
   // Holds a command over one taking edge; the idle operand is inverted
   // so that stale data can never pass for a fresh command.
   task automatic op(input csfa_op_t o, input csfa_width_t w,
                     input logic [15:0] d, input logic v);
      @(posedge clk) #1;
      cmd_valid   = 1'b1;
      cmd_op      = o;
      cmd_width   = w;
      cmd_operand = d;
      cmd_bit_val = v;
      @(posedge clk) #1;
      cmd_valid   = 1'b0;
      cmd_operand = ~d;
      cmd_bit_val = ~v;
   endtask
endmodule // csfa_exec_model

// file: tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// Bench for the work register and status word.
module tb_top;
   import csfa_pkg::*;
   logic        clk, rst, ext_reset_pin_low, break_reset, wdt_reset, trap_reset;
   logic        cmd_valid, cmd_bit_val, int_enter, int_maskable, int_return;
   logic        mem_req, mem_word, width_view_ff, sw_save_valid_ff, mem_valid_ff;
   logic        cmd_bit_in_sw, maskable_req, maskable_take_ff;
   csfa_op_t    cmd_op;
   csfa_width_t cmd_width;
   logic [1:0]  sw_wr_be;
   logic [2:0]  bit_num_ff;
   logic [3:0]  cmd_bit_sel;
   logic [4:0]  bit_offset_ff;
   logic [15:0] cmd_operand, sw_wr_data, int_restore_data, mem_addr, awr_ff, sw_ff;
   logic [15:0] sw_save_data_ff, common_top_ff, ptr_set_base_ff, mem_lo_addr_ff;
   logic [15:0] mem_hi_addr_ff;
   logic [15:0] tops [4] = '{16'h03FF, 16'h1FFF, 16'h3FFF, 16'h7FFF};
   logic [31:0] exp_q [$];
   logic [31:0] rs;
   int          n_errors, checks;
   csfa_exec_model csfa_exec_model_i (.clk, .cmd_valid, .cmd_op, .cmd_width,
      .cmd_operand, .cmd_bit_val);
   csfa_core csfa_core_i (.clk, .rst, .ext_reset_pin_low, .break_reset, .wdt_reset,
      .trap_reset, .cmd_valid, .cmd_op, .cmd_width, .cmd_operand, .cmd_bit_sel,
      .cmd_bit_in_sw, .cmd_bit_val, .sw_wr_be, .sw_wr_data, .int_enter,
      .int_maskable, .int_return, .int_restore_data, .maskable_req, .mem_req,
      .mem_word, .mem_addr, .awr_ff, .sw_ff, .width_view_ff, .bit_offset_ff, .bit_num_ff,
      .sw_save_data_ff, .sw_save_valid_ff, .maskable_take_ff, .common_top_ff,
      .ptr_set_base_ff, .mem_valid_ff, .mem_lo_addr_ff, .mem_hi_addr_ff);
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic tick();
      @(posedge clk) #1;
   endtask
   task automatic wr(input logic [1:0] be, input logic [15:0] d);
      tick();
      sw_wr_be   = be;
      sw_wr_data = d;
      tick();
      sw_wr_be   = 2'b00;
      sw_wr_data = ~d;
   endtask
   task automatic irq(input logic e, input logic r, input logic [15:0] d);
      tick();
      {int_enter, int_maskable, int_return, int_restore_data} = {e, e, r, d};
      tick();
      {int_enter, int_maskable, int_return, int_restore_data} = {3'b000, ~d};
   endtask
   task automatic mem(input logic w, input logic [15:0] a);
      tick();
      {mem_req, mem_word, mem_addr} = {1'b1, w, a};
      tick();
      {mem_req, mem_word, mem_addr} = {1'b0, ~w, ~a};
   endtask
   task automatic cause(input int i);
      tick();
      {ext_reset_pin_low, break_reset, wdt_reset, trap_reset} = 4'b1000 ^ (4'b1000 >> i);
      tick();
      {ext_reset_pin_low, break_reset, wdt_reset, trap_reset} = 4'b1000;
   endtask
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // A hang counts as a mismatch and ends the run.
   initial begin
      #20000;
      n_errors++;
      give_verdict();
   end
   // Scoreboard: every design pulse takes the oldest note.
   always @(posedge clk) begin
      #2;
      if (mem_valid_ff === 1'b1)
         check({mem_lo_addr_ff, mem_hi_addr_ff}, exp_q.pop_front());
      if (sw_save_valid_ff === 1'b1)
         check({16'h0000, sw_save_data_ff}, exp_q.pop_front());
   end
   // Main sequence.
   initial begin
      logic [15:0] s;
      logic [7:0]  p;
      rs = 32'hF64463A8;
      {rst, ext_reset_pin_low, break_reset, wdt_reset, trap_reset} = 5'b11000;
      {int_enter, int_maskable, int_return, int_restore_data} = 19'h00000;
      {mem_req, mem_word, mem_addr, sw_wr_be, sw_wr_data} = 36'h000000000;
      {cmd_bit_in_sw, cmd_bit_sel, maskable_req} = 6'h00;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      check(awr_ff, 16'h0000);
      check(sw_ff, 16'h0000);
      check(common_top_ff, 16'h03FF);
      $display("test reset done");
      csfa_exec_model_i.op(CSFA_OP_LOAD, CSFA_W_WORD, 16'hFFFF, 1'b0);
      check(awr_ff, 16'hFFFF);
      check(sw_ff[12], 1'b1);
      csfa_exec_model_i.op(CSFA_OP_ADD, CSFA_W_WORD, 16'h0001, 1'b0);
      check(awr_ff, 16'h0000);
      check(sw_ff[15:13], 3'b111);
      csfa_exec_model_i.op(CSFA_OP_LOAD, CSFA_W_BYTE, 16'h007F, 1'b0);
      check(awr_ff, 16'h007F);
      check(width_view_ff, 1'b0);
      csfa_exec_model_i.op(CSFA_OP_ADD, CSFA_W_DESC, 16'h0001, 1'b0);
      check(awr_ff, 16'h0080);
      check(sw_ff[15:11], 5'b00101);
      check(sw_ff[9], 1'b1);
      csfa_exec_model_i.op(CSFA_OP_BIT_TST, CSFA_W_BYTE, 16'h0000, 1'b0);
      check(sw_ff[14], 1'b1);
      check({bit_offset_ff, bit_num_ff}, 8'h80);
      csfa_exec_model_i.op(CSFA_OP_CY_LOAD, CSFA_W_BYTE, 16'h0000, 1'b1);
      check(sw_ff[15:14], 2'b11);
      wr(2'b10, 16'h1000);
      check(width_view_ff, 1'b0);
      csfa_exec_model_i.op(CSFA_OP_NOP, CSFA_W_BYTE, 16'h0000, 1'b0);
      check(width_view_ff, 1'b1);
      csfa_exec_model_i.op(CSFA_OP_SUB, CSFA_W_DESC, 16'h0081, 1'b0);
      check(awr_ff, 16'hFFFF);
      check(sw_ff[15:9], 7'b1011100);
      csfa_exec_model_i.op(CSFA_OP_CMP, CSFA_W_WORD, 16'hFFFF, 1'b0);
      check({awr_ff, sw_ff[15:13]}, {16'hFFFF, 3'b010});
      csfa_exec_model_i.op(CSFA_OP_XOR, CSFA_W_BYTE, 16'h00FF, 1'b0);
      check({awr_ff, sw_ff[14], sw_ff[11]}, {16'hFF00, 2'b10});
      csfa_exec_model_i.op(CSFA_OP_AND, CSFA_W_WORD, 16'h0F0F, 1'b0);
      check(awr_ff, 16'h0F00);
      csfa_exec_model_i.op(CSFA_OP_OR, CSFA_W_WORD, 16'h8000, 1'b0);
      check({awr_ff, sw_ff[15:11]}, {16'h8F00, 5'b00011});
      csfa_exec_model_i.op(CSFA_OP_CLR_WID, CSFA_W_BYTE, 16'h0000, 1'b0);
      check({sw_ff[12], width_view_ff}, 2'b00);
      csfa_exec_model_i.op(CSFA_OP_SET_WID, CSFA_W_BYTE, 16'h0000, 1'b0);
      check({sw_ff[12], width_view_ff}, 2'b11);
      csfa_exec_model_i.op(CSFA_OP_LOAD_SW, CSFA_W_WORD, 16'h0000, 1'b0);
      check({awr_ff, sw_ff & 16'hBFFF}, {16'h1800, 16'h1800});
      {cmd_bit_in_sw, cmd_bit_sel} = 5'h1E;
      csfa_exec_model_i.op(CSFA_OP_BIT_SET, CSFA_W_BYTE, 16'h0000, 1'b0);
      check(sw_ff[14], 1'b1);
      csfa_exec_model_i.op(CSFA_OP_BIT_CLR, CSFA_W_BYTE, 16'h0000, 1'b0);
      check(sw_ff[14], 1'b0);
      cmd_bit_sel = 4'hA;
      csfa_exec_model_i.op(CSFA_OP_BIT_SET, CSFA_W_BYTE, 16'h0000, 1'b0);
      check(sw_ff[14:10], 5'b10111);
      cmd_bit_in_sw = 1'b0;
      $display("test arithmetic done");
      wr(2'b10, 16'h0500);
      for (int k = 0; k < 4; k++) begin
         p = 8'(rnd());
         s = {8'h05, p[7:6], k[1:0], p[3:0]};
         wr(2'b01, {~s[15:8], s[7:0]});
         check(sw_ff, s);
         tick();
         check(common_top_ff, tops[k]);
         check(ptr_set_base_ff, 16'h0200 + {10'h000, p[2:0], 3'h0});
      end
      maskable_req = 1'b1;
      tick();
      check(maskable_take_ff, 1'b1);
      exp_q.push_back({16'h0000, s});
      irq(1'b1, 1'b0, 16'h0000);
      check(sw_ff[8], 1'b0);
      tick();
      check(maskable_take_ff, 1'b0);
      s = 16'(rnd());
      irq(1'b0, 1'b1, s);
      check(sw_ff, s);
      check(width_view_ff, s[12]);
      tick();
      check(maskable_take_ff, s[8]);
      maskable_req = 1'b0;
      $display("test status word done");
      for (int i = 0; i < 4; i++) begin
         s = 16'(rnd());
         exp_q.push_back(i[0] ? {s & 16'hFFFE, s | 16'h0001} : {s, s});
         mem(i[0], s);
      end
      tick();
      check(exp_q.size(), 0);
      $display("test memory done");
      for (int i = 0; i < 4; i++) begin
         csfa_exec_model_i.op(CSFA_OP_LOAD, CSFA_W_WORD, 16'(rnd()) | 16'h0001, 1'b0);
         cause(i);
         check(awr_ff, 16'h0000);
         check(sw_ff, 16'h0000);
      end
      $display("test reset causes done");
      give_verdict();
   end
endmodule // tb_top
